// file: testbench/icrb_register_bank_sva.sv
// port-level checks on the imager configuration register bank
module icrb_register_bank_sva #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb side
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic              pslverr,
	// configuration outputs
	input wire logic              analog_clk_en,
	input wire logic              logic_clk_en,
	input wire logic              clk_src_pll,
	input wire logic              adc_8bit_mode,
	input wire logic              logic_enable,
	input wire logic              core_power_up,
	input wire logic              column_mux_power_up,
	input wire logic [3:0]        double_slope_level,
	input wire logic [3:0]        triple_slope_level,
	input wire logic              frontend_power_up,
	input wire logic              bandgap_power_up,
	input wire logic              external_resistor_sel,
	input wire logic [3:0]        precharge_current_trim,
	input wire logic [3:0]        column_bias_current_trim,
	input wire logic [3:0]        pump_current_trim,
	input wire logic [3:0]        selector_first_stage_trim,
	input wire logic [3:0]        selector_second_stage_trim
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// access decode
	logic wr;
	assign wr = psel & penable & pwrite;
	// full compare so misaligned byte addresses never count as a hit
	function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// write effects, one per register whose outputs are ports here
	property p_clk_gen; wr && at(paddr, icrb_pkg::IDX_CLOCK_GEN_CONTROL) && pstrb[0] |=>
		{adc_8bit_mode, clk_src_pll, logic_clk_en, analog_clk_en} == $past(pwdata[3:0]); endproperty
	a_clk_gen: assert property (p_clk_gen) else $error("clock generator bits wrong");
	property p_logic; wr && at(paddr, icrb_pkg::IDX_LOGIC_ENABLE) && pstrb[0] |=> logic_enable == $past(pwdata[0]);
	endproperty
	a_logic: assert property (p_logic) else $error("logic enable wrong");
	property p_img; wr && at(paddr, icrb_pkg::IDX_IMAGER_POWER) && pstrb[0] |=>
		{column_mux_power_up, core_power_up} == $past(pwdata[1:0]); endproperty
	a_img: assert property (p_img) else $error("image core power wrong");
	property p_slope; wr && at(paddr, icrb_pkg::IDX_IMAGER_SLOPE) && pstrb[0] |=>
		{triple_slope_level, double_slope_level} == $past(pwdata[7:0]); endproperty
	a_slope: assert property (p_slope) else $error("slope levels wrong");
	property p_fe; wr && at(paddr, icrb_pkg::IDX_FRONTEND_POWER) && pstrb[0] |=> frontend_power_up == $past(pwdata[0]);
	endproperty
	a_fe: assert property (p_fe) else $error("front end power wrong");
	property p_bg; wr && at(paddr, icrb_pkg::IDX_REFERENCE_POWER) && pstrb[0] |=> bandgap_power_up == $past(pwdata[0]);
	endproperty
	a_bg: assert property (p_bg) else $error("bandgap power wrong");
	property p_bias; wr && at(paddr, icrb_pkg::IDX_BIAS_CURRENT) && pstrb[1:0] == 2'h3 |=>
		{pump_current_trim, column_bias_current_trim, precharge_current_trim, external_resistor_sel}
		== {$past(pwdata[15:4]), $past(pwdata[0])}; endproperty
	a_bias: assert property (p_bias) else $error("bias setup wrong");
	property p_sel; wr && at(paddr, icrb_pkg::IDX_COLUMN_MUX_CURRENT) && pstrb[0] |=>
		{selector_second_stage_trim, selector_first_stage_trim} == $past(pwdata[7:0]); endproperty
	a_sel: assert property (p_sel) else $error("selector trims wrong");
	// ==========================================
	// reset values seen right after release, and five sampled outputs held without a write
	property p_reset; $rose(presetn) |-> clk_src_pll && !adc_8bit_mode && double_slope_level == 4'hA
		&& external_resistor_sel && pump_current_trim == 4'h8 && selector_second_stage_trim == 4'h8; endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");
	property p_hold; !wr |=> $stable({analog_clk_en, clk_src_pll, logic_enable, double_slope_level, pump_current_trim});
	endproperty
	a_hold: assert property (p_hold) else $error("output moved without a write");
	c_clk_gen: cover property (wr && at(paddr, icrb_pkg::IDX_CLOCK_GEN_CONTROL));
	c_refused: cover property (psel && penable && pslverr);
	c_release: cover property ($rose(presetn));
endmodule

// file: testbench/tb_imager_config_register_bank.sv
// self-checking bench for the imager configuration register bank
module tb_imager_config_register_bank;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ADDR_W = 12;
	// ==========================================
	// design signals
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, er, analog_clk_en, logic_clk_en, clk_src_pll, adc_8bit_mode, logic_enable;
	logic core_power_up, column_mux_power_up, column_bias_enable, frontend_power_up, bandgap_power_up;
	logic external_resistor_sel;
	logic [3:0] double_slope_level, triple_slope_level, precharge_current_trim, column_bias_current_trim;
	logic [3:0] pump_current_trim, frontend_current_trim, converter_ref_trim, selector_first_stage_trim;
	logic [3:0] selector_second_stage_trim, serial_out_current_trim, serial_out_ref_trim;
	logic [6:0] amplifier_ref_trim;
	// grouped views of the outputs, to keep the compares short
	logic [5:0]  pwr_seen;
	logic [15:0] bias_seen;
	assign pwr_seen  = {logic_enable, core_power_up, column_mux_power_up, column_bias_enable, frontend_power_up,
		bandgap_power_up};
	assign bias_seen = {pump_current_trim, column_bias_current_trim, precharge_current_trim, 3'h0,
		external_resistor_sel};
	int num_errors = 0, checks_done = 0, cycles = 0;
	always #5 pclk = ~pclk;
	icrb_register_bank #(.ADDR_W(ADDR_W)) DUT (.*);
	// ==========================================
	// reporting; the cycle ceiling sits far above the fewer than two hundred cycles needed
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ==========================================
	// apb master: setup, then hold the access until pready is sampled high
	function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
		return ADDR_W'({idx, 2'b00});
	endfunction
	task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [15:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] s);
		xfer(ba(idx), 1'b1, d, s);
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset_vals();
		for (int i = 0; i < icrb_pkg::NUM_REGS; i++) begin
			xfer(ba(icrb_pkg::REG_INDEX[i]), 1'b0, 16'h0000, 4'h0);
			check(rd, {16'h0000, icrb_pkg::REG_RESET[i]});
		end
		check({adc_8bit_mode, clk_src_pll, logic_clk_en, analog_clk_en}, 32'h4);
		check(pwr_seen, 32'h0);
		check({triple_slope_level, double_slope_level}, 32'h5A);
		check(bias_seen, 32'h8881);
		check({selector_second_stage_trim, selector_first_stage_trim}, 32'h88);
		check({amplifier_ref_trim, converter_ref_trim, frontend_current_trim}, 32'h53C8);
		check({serial_out_ref_trim, serial_out_current_trim}, 32'h88);
		check(pready, 32'h1);
	endtask
	// every source, mode and enable combination, ending with all ones
	task automatic t_clk_gen();
		for (int v = 0; v < 16; v++) begin
			wr(icrb_pkg::IDX_CLOCK_GEN_CONTROL, 16'(v), 4'h1);
			check({adc_8bit_mode, clk_src_pll, logic_clk_en, analog_clk_en}, 32'(v));
		end
	endtask
	task automatic t_power();
		for (int p = 1; p >= 0; p--) begin
			wr(icrb_pkg::IDX_LOGIC_ENABLE, 16'(p), 4'h3);
			wr(icrb_pkg::IDX_IMAGER_POWER, 16'(7 * p), 4'h3);
			wr(icrb_pkg::IDX_FRONTEND_POWER, 16'(p), 4'h3);
			wr(icrb_pkg::IDX_REFERENCE_POWER, 16'(p), 4'h3);
			check(pwr_seen, 32'(63 * p));
		end
		wr(icrb_pkg::IDX_IMAGER_POWER, 16'h0002, 4'h1);
		check({core_power_up, column_mux_power_up}, 32'h1);
	endtask
	// reserved fields rewritten with their reset values; byte lanes split
	task automatic t_trims();
		wr(icrb_pkg::IDX_IMAGER_SLOPE, 16'h0BC3, 4'h3);
		check({triple_slope_level, double_slope_level}, 32'hC3);
		wr(icrb_pkg::IDX_BIAS_CURRENT, 16'hFF7A, 4'h1);
		check(bias_seen, 32'h8870);
		wr(icrb_pkg::IDX_BIAS_CURRENT, 16'hB500, 4'h2);
		check({pump_current_trim, column_bias_current_trim, precharge_current_trim}, 32'hB57);
		xfer(ba(icrb_pkg::IDX_BIAS_CURRENT), 1'b0, 16'h0000, 4'h0);
		check(rd, 32'hB57A);
		wr(icrb_pkg::IDX_BIAS_CURRENT, 16'h4C3B, 4'h3);
		check(bias_seen, 32'h4C31);
		wr(icrb_pkg::IDX_FRONTEND_CURRENT, 16'h1234, 4'h3);
		check({amplifier_ref_trim, converter_ref_trim, frontend_current_trim}, 32'h1234);
		wr(icrb_pkg::IDX_COLUMN_MUX_CURRENT, 16'h8821, 4'h3);
		check({selector_second_stage_trim, selector_first_stage_trim}, 32'h21);
	endtask
	// unmapped and misaligned accesses leave the clock controls alone
	task automatic t_refuse();
		xfer(ba(8'h21), 1'b1, 16'h0000, 4'h3);
		check(er, 1'b1);
		xfer(ba(icrb_pkg::IDX_CLOCK_GEN_CONTROL) | ADDR_W'(1), 1'b1, 16'h0000, 4'h3);
		check(er, 1'b1);
		check({adc_8bit_mode, clk_src_pll, logic_clk_en, analog_clk_en}, 32'hF);
		xfer(ba(8'h21), 1'b0, 16'h0000, 4'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
	endtask
	initial begin
		do_reset();
		t_reset_vals();
		t_clk_gen();
		t_power();
		t_trims();
		t_refuse();
		do_reset();
		t_reset_vals();
		tally_and_finish();
	end
endmodule
bind icrb_register_bank icrb_register_bank_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// file: verilog/icrb_pkg.sv
// register map, field layout and reset values of the imager configuration bank
package icrb_pkg;

	// ==========================================
	// register word and map geometry
	typedef logic [15:0] icrb_word_t;
	typedef logic [3:0]  icrb_slot_t;

	localparam int         NUM_REGS  = 12;
	localparam int         WORD_W    = 16;
	localparam int         MIN_ADDR_W = 9;
	localparam icrb_slot_t SLOT_NONE = 4'hF;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// ==========================================
	// printed register indices; byte address is four times the index
	localparam logic [7:0] IDX_SPARE_WORD_26      = 8'h1A;
	localparam logic [7:0] IDX_SPARE_WORD_27      = 8'h1B;
	localparam logic [7:0] IDX_CLOCK_GEN_CONTROL  = 8'h20;
	localparam logic [7:0] IDX_LOGIC_ENABLE       = 8'h22;
	localparam logic [7:0] IDX_IMAGER_POWER       = 8'h28;
	localparam logic [7:0] IDX_IMAGER_SLOPE       = 8'h29;
	localparam logic [7:0] IDX_FRONTEND_POWER     = 8'h30;
	localparam logic [7:0] IDX_REFERENCE_POWER    = 8'h40;
	localparam logic [7:0] IDX_BIAS_CURRENT       = 8'h41;
	localparam logic [7:0] IDX_FRONTEND_CURRENT   = 8'h42;
	localparam logic [7:0] IDX_COLUMN_MUX_CURRENT = 8'h43;
	localparam logic [7:0] IDX_SERIAL_OUT_CURRENT = 8'h44;

	// storage slots, in the same order as the tables below
	localparam icrb_slot_t SLOT_SPARE_26 = 4'h0;
	localparam icrb_slot_t SLOT_SPARE_27 = 4'h1;
	localparam icrb_slot_t SLOT_CLK_GEN  = 4'h2;
	localparam icrb_slot_t SLOT_LOGIC    = 4'h3;
	localparam icrb_slot_t SLOT_IMG_PWR  = 4'h4;
	localparam icrb_slot_t SLOT_SLOPE    = 4'h5;
	localparam icrb_slot_t SLOT_FE_PWR   = 4'h6;
	localparam icrb_slot_t SLOT_REF_PWR  = 4'h7;
	localparam icrb_slot_t SLOT_BIAS     = 4'h8;
	localparam icrb_slot_t SLOT_FE_CUR   = 4'h9;
	localparam icrb_slot_t SLOT_MUX_CUR  = 4'hA;
	localparam icrb_slot_t SLOT_SER_CUR  = 4'hB;

	localparam logic [7:0] REG_INDEX [NUM_REGS] = '{
		IDX_SPARE_WORD_26, IDX_SPARE_WORD_27, IDX_CLOCK_GEN_CONTROL, IDX_LOGIC_ENABLE,
		IDX_IMAGER_POWER, IDX_IMAGER_SLOPE, IDX_FRONTEND_POWER, IDX_REFERENCE_POWER,
		IDX_BIAS_CURRENT, IDX_FRONTEND_CURRENT, IDX_COLUMN_MUX_CURRENT, IDX_SERIAL_OUT_CURRENT};

	localparam icrb_word_t REG_RESET [NUM_REGS] = '{
		16'h2280, 16'h3D2D, 16'h0004, 16'h0000, 16'h0000, 16'h0B5A,
		16'h0000, 16'h0000, 16'h888B, 16'h53C8, 16'h8888, 16'h0088};

	// bits that exist; all others read zero and ignore writes
	localparam icrb_word_t REG_MASK [NUM_REGS] = '{
		16'h7FFF, 16'hFFFF, 16'h7F0F, 16'h0001, 16'h0007, 16'hFFFF,
		16'h0001, 16'h0001, 16'hFFFF, 16'h7FFF, 16'hFFFF, 16'h00FF};

	// ==========================================
	// field positions
	localparam int BIT_ANALOG_CLK_EN  = 0;
	localparam int BIT_LOGIC_CLK_EN   = 1;
	localparam int BIT_SELECT_PLL     = 2;
	localparam int BIT_ADC_8BIT       = 3;
	localparam int BIT_LOGIC_ENABLE   = 0;
	localparam int BIT_CORE_PWR_UP    = 0;
	localparam int BIT_MUX_PWR_UP     = 1;
	localparam int BIT_COL_BIAS_EN    = 2;
	localparam int BIT_FE_PWR_UP      = 0;
	localparam int BIT_BANDGAP_PWR_UP = 0;
	localparam int BIT_EXT_RESISTOR   = 0;
	localparam int TRIM_W             = 4;
	localparam int LSB_DOUBLE_SLOPE   = 0;
	localparam int LSB_TRIPLE_SLOPE   = 4;
	localparam int LSB_PRECHARGE      = 4;
	localparam int LSB_COL_BIAS       = 8;
	localparam int LSB_PUMP           = 12;
	localparam int LSB_FE_IBIAS       = 0;
	localparam int LSB_ADC_IREF       = 4;
	localparam int LSB_PGA_IREF       = 8;
	localparam int PGA_IREF_W         = 7;
	localparam int LSB_STAGE1         = 0;
	localparam int LSB_STAGE2         = 4;
	localparam int LSB_SER_IBIAS      = 0;
	localparam int LSB_SER_IREF       = 4;

endpackage

// file: verilog/icrb_register_bank.sv
// apb slave holding the imager clock, power and bias configuration registers
//
// How it works
// (R1) bit 0 at 32 gates analog clocks
// (R2) bit 1 at 32 enables logic clock
// (R3) bit 2 at 32 picks PLL, resets one
// (R4) bit 3 at 32 selects eight-bit conversion
// (R5) bit 0 at 34 enables general logic
// (R6) bit 0 at 40 powers image core
// (R7) bit 1 at 40 powers column multiplexer
// (R8) register 41 holds two slope levels
// (R9) bit 0 at 48 powers all converters
// (R10) bit 0 at 64 powers bandgap reference
// (R11) bit 0 at 65 picks external resistor
// (R12) register 65 holds three current trims
// (R13) register 67 holds two selector trims
// (R14) host rewrites reserved fields with reset values
module icrb_register_bank #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// clock generator controls
	output logic                       analog_clk_en,
	output logic                       logic_clk_en,
	output logic                       clk_src_pll,
	output logic                       adc_8bit_mode,
	// general logic
	output logic                       logic_enable,
	// image core
	output logic                       core_power_up,
	output logic                       column_mux_power_up,
	output logic                       column_bias_enable,
	output logic [3:0]                 double_slope_level,
	output logic [3:0]                 triple_slope_level,
	// front end and reference power
	output logic                       frontend_power_up,
	output logic                       bandgap_power_up,
	// bias trims
	output logic                       external_resistor_sel,
	output logic [3:0]                 precharge_current_trim,
	output logic [3:0]                 column_bias_current_trim,
	output logic [3:0]                 pump_current_trim,
	output logic [3:0]                 frontend_current_trim,
	output logic [3:0]                 converter_ref_trim,
	output logic [6:0]                 amplifier_ref_trim,
	output logic [3:0]                 selector_first_stage_trim,
	output logic [3:0]                 selector_second_stage_trim,
	output logic [3:0]                 serial_out_current_trim,
	output logic [3:0]                 serial_out_ref_trim
);

	// ==========================================
	// elaboration check; too few bits cannot reach the highest register index
	if (ADDR_W < icrb_pkg::MIN_ADDR_W || ADDR_W > 32) begin : g_addr_w_check
		$error("icrb_register_bank: ADDR_W out of range");
	end

	// ==========================================
	// helper functions

	// byte address to storage slot, SLOT_NONE when unmapped or misaligned
	function automatic icrb_pkg::icrb_slot_t icrb_decode(input logic [ADDR_W-1:0] addr);
		icrb_pkg::icrb_slot_t slot;
		logic [ADDR_W-3:0]    word;
		slot = icrb_pkg::SLOT_NONE;
		word = addr[ADDR_W-1:2];
		if (addr[1:0] == icrb_pkg::WORD_ALIGN) begin
			for (int i = 0; i < icrb_pkg::NUM_REGS; i++) begin
				if (word == (ADDR_W-2)'(icrb_pkg::REG_INDEX[i])) begin
					slot = icrb_pkg::icrb_slot_t'(i);
				end
			end
		end
		return slot;
	endfunction

	// byte-lane merge of a write; only the low two lanes reach the 16-bit word
	function automatic icrb_pkg::icrb_word_t icrb_merge(
		input icrb_pkg::icrb_word_t old_val,
		input logic [31:0]          wdata,
		input logic [3:0]           strb,
		input icrb_pkg::icrb_word_t mask
	);
		icrb_pkg::icrb_word_t lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
		lanes = lanes & mask;
		return (old_val & ~lanes) | (wdata[15:0] & lanes);
	endfunction

	// ==========================================
	// storage and bus state
	icrb_pkg::icrb_word_t regs_r [icrb_pkg::NUM_REGS];
	icrb_pkg::icrb_slot_t slot;
	logic                 setup;
	logic                 access;
	logic                 unmapped;
	logic [31:0]          prdata_r;
	logic                 err_r;

	// address decode shared by read capture and write
	assign slot     = icrb_decode(paddr);
	assign unmapped = (slot == icrb_pkg::SLOT_NONE);
	assign setup    = psel & ~penable;
	assign access   = psel & penable;

	// zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = access & err_r;
	assign prdata  = prdata_r;

	// ==========================================
	// register writes
	// reserved bits are stored as written, so a host that keeps them at reset values keeps them intact
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < icrb_pkg::NUM_REGS; i++) begin
				regs_r[i] <= icrb_pkg::REG_RESET[i];
			end
		end else if (access && pwrite && !unmapped) begin
			for (int i = 0; i < icrb_pkg::NUM_REGS; i++) begin
				if (slot == icrb_pkg::icrb_slot_t'(i)) begin
					regs_r[i] <= icrb_merge(regs_r[i], pwdata, pstrb, icrb_pkg::REG_MASK[i]);
				end
			end
		end
	end

	// ==========================================
	// read data and error captured in the setup cycle
	// registering here keeps prdata off the decode path at the cost of nothing, since the access cycle follows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			err_r    <= 1'b0;
		end else if (setup) begin
			err_r    <= unmapped;
			prdata_r <= 32'h0000_0000;
			if (!pwrite && !unmapped) begin
				prdata_r <= {16'h0000, regs_r[slot] & icrb_pkg::REG_MASK[slot]};
			end
		end
	end

	// ==========================================
	// clock generator controls
	assign analog_clk_en = regs_r[icrb_pkg::SLOT_CLK_GEN][icrb_pkg::BIT_ANALOG_CLK_EN]; // R1
	assign logic_clk_en  = regs_r[icrb_pkg::SLOT_CLK_GEN][icrb_pkg::BIT_LOGIC_CLK_EN];  // R2
	assign clk_src_pll   = regs_r[icrb_pkg::SLOT_CLK_GEN][icrb_pkg::BIT_SELECT_PLL];    // R3
	assign adc_8bit_mode = regs_r[icrb_pkg::SLOT_CLK_GEN][icrb_pkg::BIT_ADC_8BIT];      // R4

	// general logic master enable
	assign logic_enable = regs_r[icrb_pkg::SLOT_LOGIC][icrb_pkg::BIT_LOGIC_ENABLE]; // R5

	// image core power, active low power-down sense: one means powered
	assign core_power_up       = regs_r[icrb_pkg::SLOT_IMG_PWR][icrb_pkg::BIT_CORE_PWR_UP]; // R6
	assign column_mux_power_up = regs_r[icrb_pkg::SLOT_IMG_PWR][icrb_pkg::BIT_MUX_PWR_UP];  // R7
	assign column_bias_enable  = regs_r[icrb_pkg::SLOT_IMG_PWR][icrb_pkg::BIT_COL_BIAS_EN];

	// slope reset levels
	assign double_slope_level =
		regs_r[icrb_pkg::SLOT_SLOPE][icrb_pkg::LSB_DOUBLE_SLOPE +: icrb_pkg::TRIM_W]; // R8
	assign triple_slope_level =
		regs_r[icrb_pkg::SLOT_SLOPE][icrb_pkg::LSB_TRIPLE_SLOPE +: icrb_pkg::TRIM_W]; // R8

	// one bit powers every converter column at once, another the bandgap reference
	assign frontend_power_up = regs_r[icrb_pkg::SLOT_FE_PWR][icrb_pkg::BIT_FE_PWR_UP];       // R9
	assign bandgap_power_up  = regs_r[icrb_pkg::SLOT_REF_PWR][icrb_pkg::BIT_BANDGAP_PWR_UP]; // R10

	// ==========================================
	// bias current setup
	assign external_resistor_sel = regs_r[icrb_pkg::SLOT_BIAS][icrb_pkg::BIT_EXT_RESISTOR]; // R11
	assign precharge_current_trim =
		regs_r[icrb_pkg::SLOT_BIAS][icrb_pkg::LSB_PRECHARGE +: icrb_pkg::TRIM_W]; // R12
	assign column_bias_current_trim =
		regs_r[icrb_pkg::SLOT_BIAS][icrb_pkg::LSB_COL_BIAS +: icrb_pkg::TRIM_W]; // R12
	assign pump_current_trim =
		regs_r[icrb_pkg::SLOT_BIAS][icrb_pkg::LSB_PUMP +: icrb_pkg::TRIM_W]; // R12

	// front end currents
	assign frontend_current_trim = regs_r[icrb_pkg::SLOT_FE_CUR][icrb_pkg::LSB_FE_IBIAS +: icrb_pkg::TRIM_W];
	assign converter_ref_trim    = regs_r[icrb_pkg::SLOT_FE_CUR][icrb_pkg::LSB_ADC_IREF +: icrb_pkg::TRIM_W];
	assign amplifier_ref_trim    = regs_r[icrb_pkg::SLOT_FE_CUR][icrb_pkg::LSB_PGA_IREF +: icrb_pkg::PGA_IREF_W];

	// column selector stages
	assign selector_first_stage_trim =
		regs_r[icrb_pkg::SLOT_MUX_CUR][icrb_pkg::LSB_STAGE1 +: icrb_pkg::TRIM_W]; // R13
	assign selector_second_stage_trim =
		regs_r[icrb_pkg::SLOT_MUX_CUR][icrb_pkg::LSB_STAGE2 +: icrb_pkg::TRIM_W]; // R13

	// serial output currents
	assign serial_out_current_trim = regs_r[icrb_pkg::SLOT_SER_CUR][icrb_pkg::LSB_SER_IBIAS +: icrb_pkg::TRIM_W];
	assign serial_out_ref_trim     = regs_r[icrb_pkg::SLOT_SER_CUR][icrb_pkg::LSB_SER_IREF +: icrb_pkg::TRIM_W];

endmodule
